// >>> bus_clock_divider.sv
`timescale 1ns/1ps
`include "reset_clock_defs.svh"

// ----------------------------------------------------------------
// Divide-by-four bus clock level
// ----------------------------------------------------------------
module bus_clock_divider (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    output logic      bus_level_o
);

    logic [`BUS_DIV_W-1:0] div;

    // Top bit of a 2-bit counter is a 50 percent quarter-rate clock
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            div <= '0;
        end else begin
            div <= div + `BUS_DIV_W'(1);
        end
    end

    assign bus_level_o = div[`BUS_DIV_W-1];

endmodule : bus_clock_divider

// >>> reset_clock_defs.svh
`ifndef RESET_CLOCK_DEFS_SVH
`define RESET_CLOCK_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    5
`define EXT_LOW_MIN_NS   20
`define EXT_LOW_MIN_CYC  ((`EXT_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_DIV_W        2
`define CNT_W            12
`define PHASE_W          6
`define LINE_LOW_LAST    6'd31
`define INTERNAL_RESET_EXTRA_LAST  6'd31
`define VECTOR_LAST      6'd2
`define SHORT_STOP_LAST  12'h01f
`define SVC_KEEP_MASK    12'h00f
`define EXT_CNT_W        3

// ----------------------------------------------------------------
// Vectors and cause bits
// ----------------------------------------------------------------
`define VEC_USER         16'hfffe
`define VEC_MONITOR      16'hfefe
`define CAUSE_W          8
`define CAUSE_POR_RESET  8'h80
`define CAUSE_POR        7
`define CAUSE_PIN        6
`define CAUSE_WDOG       5
`define CAUSE_OPCODE     4
`define CAUSE_FETCH      3
`define CAUSE_BROWNOUT   1

`endif

// >>> reset_clock_pkg.sv
package reset_clock_pkg;

    // Sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_RUN    = 8'h01,
        ST_LONG   = 8'h02,
        ST_DRIVE  = 8'h04,
        ST_EXTEND = 8'h08,
        ST_VECTOR = 8'h10,
        ST_EXT    = 8'h20,
        ST_STOP   = 8'h40,
        ST_WAKE   = 8'h80
    } seq_state_t;

endpackage : reset_clock_pkg

// >>> reset_clock_sequencer.sv
`timescale 1ns/1ps
`include "reset_clock_defs.svh"
module reset_clock_sequencer
    import reset_clock_pkg::*;
(
    input  wire logic            ref_clk_i,
    input  wire logic            rstn_i,
    input  wire logic            power_up_pulse_i,
    input  wire logic            brownout_i,
    input  wire logic            ext_reset_line_i,
    input  wire logic            reset_line_enable_i,
    input  wire logic            short_stop_recovery_i,
    input  wire logic            watchdog_timeout_i,
    input  wire logic            service_write_i,
    input  wire logic            monitor_mode_i,
    input  wire logic            break_active_i,
    input  wire logic            break_disables_watchdog_i,
    input  wire logic            bad_opcode_i,
    input  wire logic            stop_instr_i,
    input  wire logic            stop_enable_i,
    input  wire logic            opcode_fetch_i,
    input  wire logic            unmapped_addr_i,
    input  wire logic            wait_mode_i,
    input  wire logic            wake_event_i,
    input  wire logic            cause_clear_i,
    output logic                 bus_clk_o,
    output logic                 cpu_clk_o,
    output logic                 periph_clk_o,
    output logic                 internal_reset_o,
    output logic                 reset_line_o,
    output logic                 reset_line_oe_n_o,
    output logic                 line_level_o,
    output logic [15:0]          reset_vector_o,
    output logic [`CAUSE_W-1:0]  reset_cause_o,
    output logic                 watchdog_tick_o,
    output logic                 watchdog_clear_o,
    output logic                 watchdog_enable_o
);

    // ----------------------------------------------------------------
    // Synchronisers and divider
    // ----------------------------------------------------------------
    logic line_s;
    logic wd_s;
    logic bus_level;

    // Idle-high line, so its synchroniser resets high
    sync_two_flop #(.RST_VAL(1'b1)) u_line_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (ext_reset_line_i),
        .q_o       (line_s)
    );

    sync_two_flop #(.RST_VAL(1'b0)) u_wdog_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (watchdog_timeout_i),
        .q_o       (wd_s)
    );

    bus_clock_divider u_div (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .bus_level_o (bus_level)
    );

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    seq_state_t            state;
    seq_state_t            next_state;
    logic [`CNT_W-1:0]     cnt;
    logic [`CNT_W-1:0]     next_cnt;
    logic [`PHASE_W-1:0]   phase;
    logic [`EXT_CNT_W-1:0] ext_cnt;
    logic [`CAUSE_W-1:0]   cause_set;

    wire st_run    = (state == ST_RUN);
    wire st_long   = (state == ST_LONG);
    wire st_drive  = (state == ST_DRIVE);
    wire st_extend = (state == ST_EXTEND);
    wire st_vector = (state == ST_VECTOR);
    wire st_ext    = (state == ST_EXT);
    wire st_stop   = (state == ST_STOP);
    wire st_wake   = (state == ST_WAKE);

    // Own drive of the line must not read back as a pin reset
    wire live       = st_run | st_stop | st_wake;
    wire line_reset = reset_line_enable_i & ~line_s;
    wire wd_ok      = ~(monitor_mode_i & break_active_i & break_disables_watchdog_i);
    wire wd_hit     = live & wd_s & wd_ok;
    wire op_hit     = st_run & (bad_opcode_i | (stop_instr_i & ~stop_enable_i));
    wire ad_hit     = st_run & opcode_fetch_i & unmapped_addr_i;
    wire long_hit   = power_up_pulse_i | brownout_i;
    wire short_hit  = wd_hit | op_hit | ad_hit;
    wire pin_hit    = live & line_reset;
    wire stop_go    = st_run & stop_instr_i & stop_enable_i;

    // Counter control: internal sources and stop clear, pin reset does not
    wire cnt_clear  = long_hit | short_hit | stop_go;
    wire cnt_carry  = &cnt;
    wire wake_done  = short_stop_recovery_i ? (cnt == `SHORT_STOP_LAST) : cnt_carry;

    wire phase_end  = (st_drive  & (phase == `LINE_LOW_LAST))
                    | (st_extend & (phase == `INTERNAL_RESET_EXTRA_LAST))
                    | (st_vector & (phase == `VECTOR_LAST));

    wire ext_met    = (ext_cnt == `EXT_CNT_W'(`EXT_LOW_MIN_CYC - 1));

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    // Power-up and brown-out pre-empt everything, even a reset in flight
    always_comb begin
        next_state = state;
        if (long_hit) begin
            next_state = ST_LONG;
        end else if (short_hit) begin
            next_state = ST_DRIVE;
        end else if (pin_hit) begin
            next_state = ST_EXT;
        end else begin
            case (state)
                ST_RUN: begin
                    if (stop_go) next_state = ST_STOP;
                end
                ST_LONG: begin
                    if (cnt_carry) next_state = ST_DRIVE;
                end
                ST_DRIVE: begin
                    if (phase_end) next_state = ST_EXTEND;
                end
                ST_EXTEND: begin
                    if (phase_end) next_state = ST_VECTOR;
                end
                ST_VECTOR: begin
                    if (phase_end) next_state = ST_RUN;
                end
                ST_EXT: begin
                    if (!line_reset) next_state = ST_EXTEND;
                end
                ST_STOP: begin
                    if (wake_event_i) next_state = ST_WAKE;
                end
                ST_WAKE: begin
                    if (wake_done) next_state = ST_RUN;
                end
                default: next_state = ST_LONG;
            endcase
        end
    end

    // Counter frozen in stop; service write trims the upper stages
    always_comb begin
        if (cnt_clear) begin
            next_cnt = '0;
        end else if (st_stop) begin
            next_cnt = cnt;
        end else if (service_write_i) begin
            next_cnt = cnt & `SVC_KEEP_MASK;
        end else begin
            next_cnt = cnt + `CNT_W'(1);
        end
    end

    // Cause flags set by this cycle's requests
    always_comb begin
        cause_set                  = '0;
        // Pin flag needs the low time, which is only reached after entry
        cause_set[`CAUSE_PIN]      = (pin_hit | (st_ext & line_reset)) & ext_met;
        cause_set[`CAUSE_WDOG]     = wd_hit;
        cause_set[`CAUSE_OPCODE]   = op_hit;
        cause_set[`CAUSE_FETCH]    = ad_hit;
        cause_set[`CAUSE_BROWNOUT] = brownout_i;
    end

    wire internal_reset_next = (next_state == ST_LONG) | (next_state == ST_DRIVE)
                             | (next_state == ST_EXTEND) | (next_state == ST_EXT);
    wire drive_next          = reset_line_enable_i
                             & ((next_state == ST_LONG) | (next_state == ST_DRIVE));
    wire cpu_on              = st_run & ~wait_mode_i;

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    // Block reset is treated as a power-up
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state <= ST_LONG;
            cnt   <= '0;
            phase <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            phase <= (next_state != state) ? '0 : phase + `PHASE_W'(1);
        end
    end

    // Pin-low duration, saturating
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ext_cnt <= '0;
        end else if (!line_reset) begin
            ext_cnt <= '0;
        end else if (!ext_met) begin
            ext_cnt <= ext_cnt + `EXT_CNT_W'(1);
        end
    end

    // Cause register: a new event beats a simultaneous clear
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            reset_cause_o <= `CAUSE_POR_RESET;
        end else if (power_up_pulse_i) begin
            reset_cause_o <= `CAUSE_POR_RESET;
        end else begin
            reset_cause_o <= (cause_clear_i ? '0 : reset_cause_o) | cause_set;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Gated clocks rest low, their inactive phase
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            bus_clk_o         <= 1'b0;
            cpu_clk_o         <= 1'b0;
            periph_clk_o      <= 1'b0;
            internal_reset_o  <= 1'b1;
            reset_line_o      <= 1'b0;
            reset_line_oe_n_o <= 1'b1;
            line_level_o      <= 1'b1;
            reset_vector_o    <= `VEC_USER;
            watchdog_tick_o   <= 1'b0;
            watchdog_clear_o  <= 1'b0;
            watchdog_enable_o <= 1'b1;
        end else begin
            bus_clk_o         <= bus_level;
            cpu_clk_o         <= bus_level & cpu_on;
            periph_clk_o      <= bus_level & st_run;
            internal_reset_o  <= internal_reset_next;
            reset_line_o      <= 1'b0;
            reset_line_oe_n_o <= ~drive_next;
            line_level_o      <= line_s;
            reset_vector_o    <= monitor_mode_i ? `VEC_MONITOR : `VEC_USER;
            watchdog_tick_o   <= cnt_carry & ~cnt_clear & ~st_stop;
            watchdog_clear_o  <= service_write_i;
            watchdog_enable_o <= wd_ok;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_drive_done;
        st_drive && phase == `LINE_LOW_LAST && !long_hit && !short_hit;
    endsequence

    sequence s_extend_start;
        st_extend && phase == '0;
    endsequence

    property p_drive_to_extend;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        s_drive_done |=> s_extend_start ##0 (reset_line_oe_n_o && internal_reset_o);
    endproperty
    a_p_drive_to_extend: assert property (p_drive_to_extend)
        else $error("line not released after 32 drive cycles");

    property p_vector_to_run;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (st_vector && phase == `VECTOR_LAST && !long_hit && !short_hit && !pin_hit)
            |=> st_run ##1 !internal_reset_o;
    endproperty
    a_p_vector_to_run: assert property (p_vector_to_run)
        else $error("vector phase did not end after 3 cycles");

    property p_long_done;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (st_long && cnt_carry && !long_hit && !short_hit && !pin_hit) |=> st_drive;
    endproperty
    a_p_long_done: assert property (p_long_done)
        else $error("long hold did not end on counter carry");

    property p_stop_clears;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        stop_go |=> (cnt == '0 && st_stop) ##1 (cnt == '0 || !st_stop);
    endproperty
    a_p_stop_clears: assert property (p_stop_clears)
        else $error("stop did not clear the counter");

    property p_short_wake;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (st_wake && short_stop_recovery_i && cnt == `SHORT_STOP_LAST && !long_hit
            && !short_hit && !pin_hit) |=> st_run;
    endproperty
    a_p_short_wake: assert property (p_short_wake)
        else $error("short stop recovery not 32 cycles");

    property p_pin_keeps_count;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (pin_hit && !long_hit && !short_hit && !service_write_i && !st_stop)
            |=> cnt == $past(cnt) + `CNT_W'(1);
    endproperty
    a_p_pin_keeps_count: assert property (p_pin_keeps_count)
        else $error("pin reset disturbed the counter");

    property p_wdog_flag;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (wd_hit && !long_hit) |=> reset_cause_o[`CAUSE_WDOG] && st_drive;
    endproperty
    a_p_wdog_flag: assert property (p_wdog_flag)
        else $error("watchdog overflow not flagged");

    property p_service_trim;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (service_write_i && !cnt_clear && !st_stop)
            |=> cnt[`CNT_W-1:4] == '0 && watchdog_clear_o;
    endproperty
    a_p_service_trim: assert property (p_service_trim)
        else $error("service write did not trim the counter");

    property p_wait_cpu_off;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (st_run && wait_mode_i) |=> !cpu_clk_o && periph_clk_o == $past(bus_level);
    endproperty
    a_p_wait_cpu_off: assert property (p_wait_cpu_off)
        else $error("wait mode clocks wrong");

    property p_opcode_flag;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op_hit && !power_up_pulse_i) |=> reset_cause_o[`CAUSE_OPCODE] && internal_reset_o;
    endproperty
    a_p_opcode_flag: assert property (p_opcode_flag)
        else $error("illegal opcode not flagged");

endmodule : reset_clock_sequencer

// >>> reset_clock_sequencer_test.sv
`timescale 1ns/1ps

module reset_clock_sequencer_test;
    // ----------------------------------------------------------------
    // Stimulus, outputs and bookkeeping
    // ----------------------------------------------------------------
    logic        ref_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        pwr, bo, en, ssr, wdt, svc, mon, brk, bdc, bop, stp, sten, fetch, unm;
    logic        wt, wake, cclr, pull, pin;
    logic        bus, cpu, per, internal_reset, line_o, oe_n, lvl, tick, wclr, wen;
    logic [15:0] vec;
    logic [7:0]  cause;
    int          err_count = 0;
    int          tests_run = 0;
    int          lo, ir, b, c, p, k, lim;
    int          hold[6] = '{1, 1, 3, 1, 10, 10};
    int          cbit[6] = '{4, 3, 5, 4, 6, 1};

    reset_clock_sequencer DUT (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .power_up_pulse_i(pwr), .brownout_i(bo),
        .ext_reset_line_i(pin), .reset_line_enable_i(en), .short_stop_recovery_i(ssr),
        .watchdog_timeout_i(wdt), .service_write_i(svc), .monitor_mode_i(mon),
        .break_active_i(brk), .break_disables_watchdog_i(bdc), .bad_opcode_i(bop),
        .stop_instr_i(stp), .stop_enable_i(sten), .opcode_fetch_i(fetch),
        .unmapped_addr_i(unm), .wait_mode_i(wt), .wake_event_i(wake), .cause_clear_i(cclr),
        .bus_clk_o(bus), .cpu_clk_o(cpu), .periph_clk_o(per), .internal_reset_o(internal_reset),
        .reset_line_o(line_o), .reset_line_oe_n_o(oe_n), .line_level_o(lvl),
        .reset_vector_o(vec), .reset_cause_o(cause), .watchdog_tick_o(tick),
        .watchdog_clear_o(wclr), .watchdog_enable_o(wen)
    );

    reset_line_model far_end (
        .drive_i(line_o), .drive_n_i(oe_n), .pull_low_i(pull), .pin_o(pin)
    );

    // 200 MHz oscillator clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    // ----------------------------------------------------------------
    // Compare and drive helpers
    // ----------------------------------------------------------------
    task automatic cmp_cnt(input string n, input int e, input int g);
        tests_run++;
        if (e != g) begin
            err_count++;
            $display("wrong value %s exp %0d got %0d", n, e, g);
        end
    endtask : cmp_cnt

    task automatic cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : cmp_val

    // Source codes: 0 opcode, 1 fetch, 2 watchdog, 3 disabled stop, 4 pin, 5 brown-out
    task automatic set_src(input int s, input logic v);
        case (s)
            0: bop = v;
            1: {fetch, unm} = {v, v};
            2: wdt = v;
            3: {stp, sten} = {v, ~v};
            4: pull = v;
            5: bo = v;
            default: ;
        endcase
    endtask : set_src

    // Holds a source for a span, counting line-low and reset cycles until reset ends
    task automatic fire(input int s, input int h, input int mx, output int l, output int r);
        int n;
        l = 0;
        r = 0;
        n = 0;
        set_src(s, 1'b1);
        // Sample first, so the cycle right after a block reset is counted too
        do begin
            if (internal_reset === 1'b1) r++;
            if (oe_n === 1'b0) l++;
            @(negedge ref_clk_i);
            n++;
            if (n == h) set_src(s, 1'b0);
        end while (n < mx && !(r > 0 && internal_reset === 1'b0));
    endtask : fire

    // Rising edges of the three clocks over 40 oscillator cycles
    task automatic rises(output int rb, output int rc, output int rp);
        logic [2:0] last;
        rb = 0;
        rc = 0;
        rp = 0;
        repeat (40) begin
            last = {bus, cpu, per};
            @(negedge ref_clk_i);
            if (bus === 1'b1 && last[2] === 1'b0) rb++;
            if (cpu === 1'b1 && last[1] === 1'b0) rc++;
            if (per === 1'b1 && last[0] === 1'b0) rp++;
        end
    endtask : rises

    task automatic gap(output int n);
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (tick !== 1'b1 && n < 9000);
    endtask : gap

    task automatic close_out();
        $display("checks %0d, wrong %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(65));
        {pwr, bo, ssr, wdt, svc, mon, brk, bdc, bop, stp, fetch, unm, wt, wake, cclr, pull} = '0;
        {en, sten} = 2'b11;
        repeat (12) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        fire(6, 0, 9000, lo, ir);
        // First count cycle lies inside block reset, before the drive is registered
        cmp_cnt("por line low", 4127, lo);
        cmp_cnt("por reset span", 4160, ir);
        cmp_val("por cause", 16'h0080, {8'h00, cause});
        cmp_val("por vector", 16'hfffe, vec);
        repeat (8) @(negedge ref_clk_i);
        rises(b, c, p);
        cmp_cnt("bus clock", 10, b);
        cmp_cnt("cpu clock", 10, c);
        $display("test power-up done");
        // Every reset source but the power-up pulse, monitor mode picked at random
        for (int s = 0; s < 6; s++) begin
            cclr = 1'b1;
            mon = 1'($urandom % 2);
            @(negedge ref_clk_i);
            cclr = 1'b0;
            fire(s, hold[s], 9000, lo, ir);
            cmp_cnt("line low", s < 4 ? 32 : (s == 5 ? hold[s] + 4127 : 0), lo);
            cmp_cnt("reset span", s < 4 ? 64 : hold[s] + (s == 4 ? 32 : 4159), ir);
            cmp_val("cause", 16'(1 << cbit[s]), {8'h00, cause});
            cmp_val("vector", mon ? 16'hfefe : 16'hfffe, vec);
            repeat (8) @(negedge ref_clk_i);
            $display("test source %0d done", s);
        end
        // Unmapped data access and pin without reset function must not reset
        {mon, fetch, unm} = 3'b001;
        fire(6, 0, 20, lo, ir);
        cmp_cnt("data access reset", 0, ir);
        {unm, en, pull} = 3'b001;
        fire(6, 0, 20, lo, ir);
        cmp_cnt("gpio pin reset", 0, ir + lo);
        cmp_val("pin level", 16'h0000, {15'h0, lvl});
        // Let the synchroniser see the high line before the reset function returns
        pull = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        en = 1'b1;
        $display("test no-reset cases done");
        // Watchdog enable over every monitor, break, disable combination
        for (int m = 0; m < 8; m++) begin
            {mon, brk, bdc} = 3'(m);
            repeat (3) @(negedge ref_clk_i);
            cmp_val("wdog enable", 16'(m != 7), {15'h0, wen});
        end
        {mon, brk, bdc} = 3'b000;
        // Wait mode stops the CPU clock and keeps the peripheral clock
        wt = 1'b1;
        rises(b, c, p);
        cmp_cnt("wait cpu clock", 0, c);
        cmp_cnt("wait periph clock", 10, p);
        wt = 1'b0;
        $display("test wait done");
        // Short then long stop recovery
        for (int r = 1; r >= 0; r--) begin
            ssr = 1'(r);
            stp = 1'b1;
            @(negedge ref_clk_i);
            stp = 1'b0;
            rises(b, c, p);
            cmp_cnt("stop cpu clock", 0, c + p);
            wake = 1'b1;
            @(negedge ref_clk_i);
            wake = 1'b0;
            k = 1;
            while (cpu !== 1'b1 && k < 9000) begin
                @(negedge ref_clk_i);
                k++;
            end
            lim = r ? 32 : 4096;
            cmp_cnt("stop recovery", 1, int'(k >= lim && k <= lim + 8));
        end
        $display("test stop done");
        // Free-running prescaler tick and service write
        gap(k);
        gap(k);
        cmp_cnt("tick spacing", 4096, k);
        // Service in mid-count so that the trim really moves the next tick
        repeat (16 + $urandom % 2000) @(negedge ref_clk_i);
        svc = 1'b1;
        k = 0;
        repeat (3) begin
            @(negedge ref_clk_i);
            svc = 1'b0;
            if (wclr === 1'b1) k++;
        end
        cmp_cnt("service clear pulse", 1, k);
        gap(k);
        cmp_cnt("tick after service", 1, int'(k >= 4077 && k <= 4096));
        $display("test watchdog done");
        close_out();
    end

    // Bounded run: about 30k cycles expected
    initial begin
        #400us;
        err_count++;
        close_out();
    end
endmodule : reset_clock_sequencer_test

// >>> reset_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Reset pin as seen from the board
// ----------------------------------------------------------------
module reset_line_model (
    input  wire logic drive_i,
    input  wire logic drive_n_i,
    input  wire logic pull_low_i,
    output logic      pin_o
);
    // Pull-up wins unless the block or a board device sinks it
    assign pin_o = ((drive_n_i === 1'b0 && drive_i === 1'b0) || pull_low_i) ? 1'b0 : 1'b1;
endmodule : reset_line_model

// >>> sync_two_flop.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage level synchroniser
// ----------------------------------------------------------------
module sync_two_flop #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic meta;

    // First stage feeds only the second
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule : sync_two_flop
